/* File: logic/ctc_regs.svh */
// What this block does
// - eleven-bit trim code, 0x000 lowest frequency
// - low eight bits drive fine capacitors directly
// - top three bits feed thermometer decoder
// - each decoder output switches one coarse capacitor
// - apply trim after delay field times tick
// - zero trim delay applies trim at once
// - settle ticks after apply set settled flag
// - fast RC trim resets to its minimum
// - fast RC clocks system until crystal settles
// - source select picks clock to measure
// - count crystal cycles over N source cycles
// - slow crystal untrimmed, serves as sleep clock
`ifndef CTC_REGS_SVH
`define CTC_REGS_SVH

`define CTC_OFS_TRIM_CODE 12'h000
`define CTC_OFS_TRIM_CTRL 12'h004
`define CTC_OFS_STATUS 12'h008
`define CTC_OFS_FAST_CFG 12'h00C
`define CTC_OFS_CAL_TARGET 12'h010
`define CTC_OFS_CAL_SELECT 12'h014
`define CTC_OFS_CAL_RESULT 12'h018

`define CTC_TRIM_W 11
`define CTC_FINE_W 8
`define CTC_COARSE_W 7
`define CTC_TRIM_RST 11'h000
`define CTC_CTRL_TRIM_DLY_LSB 0
`define CTC_CTRL_SETTLE_DLY_LSB 4
`define CTC_CTRL_XTAL_EN_BIT 8
`define CTC_CTRL_SLEEP_SEL_BIT 9
`define CTC_CTRL_RST 10'h000
`define CTC_FAST_TRIM_W 4
`define CTC_FAST_TRIM_RST 4'h0
`define CTC_SEL_START_BIT 2
`define CTC_CAL_TARGET_RST 32'h0000_0000

`define CTC_CLK_PERIOD_PS 8000
`define CTC_TICK_PS 250000000
`define CTC_TICK_CYCLES ((`CTC_TICK_PS) / (`CTC_CLK_PERIOD_PS))

`endif

/* File: logic/ctc_pkg.sv */
`default_nettype none
package ctc_pkg;

  typedef enum logic [1:0] {
    CTC_SEQ_IDLE = 2'b00,
    CTC_SEQ_TRIM_WAIT = 2'b01,
    CTC_SEQ_SETTLE = 2'b10,
    CTC_SEQ_READY = 2'b11
  } ctc_seq_t;

  typedef enum logic [1:0] {
    CTC_SRC_SLOW_RC = 2'b00,
    CTC_SRC_FAST_RC = 2'b01,
    CTC_SRC_SLOW_XTAL = 2'b10,
    CTC_SRC_ENH_RC = 2'b11
  } ctc_src_t;

endpackage
`default_nettype wire

/* File: logic/ctc_clock_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ctc_regs.svh"

module ctc_clock_ctrl
  import ctc_pkg::*;
#(
  parameter int TICK_CYCLES = `CTC_TICK_CYCLES,
  parameter int CAL_W = 32
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fast_crystal_osc_clk,
  input wire logic slow_crystal_osc_clk,
  input wire logic fast_rc_osc_clk,
  input wire logic slow_rc_osc_clk,
  input wire logic enhanced_rc_osc_clk,
  output logic fast_crystal_osc_en,
  output logic [`CTC_FINE_W-1:0] trim_fine,
  output logic [`CTC_COARSE_W-1:0] trim_coarse,
  output logic [`CTC_FAST_TRIM_W-1:0] fast_rc_trim,
  output logic sys_clk_from_crystal,
  output logic sleep_clk_from_crystal,
  output logic trim_applied_flag,
  output logic crystal_settled_flag
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // apb decode
  wire logic access = psel & penable;
  wire logic wr_en = access & pwrite;
  wire logic hit_trim = (paddr == `CTC_OFS_TRIM_CODE);
  wire logic hit_ctrl = (paddr == `CTC_OFS_TRIM_CTRL);
  wire logic hit_stat = (paddr == `CTC_OFS_STATUS);
  wire logic hit_fast = (paddr == `CTC_OFS_FAST_CFG);
  wire logic hit_tgt = (paddr == `CTC_OFS_CAL_TARGET);
  wire logic hit_sel = (paddr == `CTC_OFS_CAL_SELECT);
  wire logic hit_res = (paddr == `CTC_OFS_CAL_RESULT);
  wire logic hit_any = hit_trim | hit_ctrl | hit_stat | hit_fast | hit_tgt | hit_sel | hit_res;
  wire logic wr_trim = wr_en & hit_trim;
  wire logic wr_ctrl = wr_en & hit_ctrl;
  wire logic wr_fast = wr_en & hit_fast;
  wire logic wr_tgt = wr_en & hit_tgt;
  wire logic wr_sel = wr_en & hit_sel;

  // zero wait states; unmapped offsets answer with an error and read zero
  assign pready = 1'b1;
  assign pslverr = access & ~hit_any;

  logic [`CTC_TRIM_W-1:0] trim_code_q;
  logic [9:0] ctrl_q;
  logic [`CTC_FAST_TRIM_W-1:0] fast_trim_q;
  logic [CAL_W-1:0] cal_target_q;
  logic [1:0] cal_src_q;
  logic cal_run_q;
  logic cal_armed_q;
  logic [CAL_W-1:0] cal_result_q;
  logic [CAL_W-1:0] cal_seen_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trim_code_q <= `CTC_TRIM_RST;
    else if (wr_trim)
      trim_code_q <= pwdata[`CTC_TRIM_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= `CTC_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= pwdata[9:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fast_trim_q <= `CTC_FAST_TRIM_RST;
    else if (wr_fast)
      fast_trim_q <= pwdata[`CTC_FAST_TRIM_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_target_q <= `CTC_CAL_TARGET_RST;
    else if (wr_tgt)
      cal_target_q <= pwdata[CAL_W-1:0];
  end

  wire logic [3:0] trim_dly = ctrl_q[`CTC_CTRL_TRIM_DLY_LSB +: 4];
  wire logic [3:0] settle_dly = ctrl_q[`CTC_CTRL_SETTLE_DLY_LSB +: 4];
  wire logic xtal_en = ctrl_q[`CTC_CTRL_XTAL_EN_BIT];

  // oscillator clocks arrive asynchronously: two flops before any use
  wire logic [4:0] osc_raw = {enhanced_rc_osc_clk, slow_crystal_osc_clk, fast_rc_osc_clk,
                              slow_rc_osc_clk, fast_crystal_osc_clk};
  logic [4:0] osc_rise;

  for (genvar g = 0; g < 5; g++)
  begin : g_osc_sync
    ctc_edge_sync sync_u
    (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(osc_raw[g]),
      .rise(osc_rise[g])
    );
  end

  wire logic xtal_rise = osc_rise[0];
  // select value low bits index the four measurable sources
  wire logic src_rise = osc_rise[3'(cal_src_q) + 3'd1];

  // crystal start-up sequencer, timed in 250 us ticks
  ctc_seq_t seq_q;
  ctc_seq_t seq_d;
  logic [TW-1:0] tick_cnt_q;
  logic [3:0] period_cnt_q;
  logic [`CTC_TRIM_W-1:0] applied_q;
  logic [`CTC_COARSE_W-1:0] coarse_q;
  logic [`CTC_FINE_W-1:0] fine_q;

  wire logic timing = (seq_q == CTC_SEQ_TRIM_WAIT) || (seq_q == CTC_SEQ_SETTLE);
  wire logic tick = timing && (tick_cnt_q == TICK_LAST);
  wire logic trim_due = (seq_q == CTC_SEQ_TRIM_WAIT) && tick && (period_cnt_q == trim_dly - 4'd1);
  wire logic settle_due = (seq_q == CTC_SEQ_SETTLE) &&
                          ((settle_dly == 4'h0) || (tick && (period_cnt_q == settle_dly - 4'd1)));
  wire logic applying = (seq_q == CTC_SEQ_IDLE && xtal_en && trim_dly == 4'h0) || trim_due;

  always_comb
  begin
    seq_d = seq_q;
    unique case (seq_q)
      CTC_SEQ_IDLE:
        if (xtal_en)
          seq_d = (trim_dly == 4'h0) ? CTC_SEQ_SETTLE : CTC_SEQ_TRIM_WAIT;
      CTC_SEQ_TRIM_WAIT:
        if (trim_due)
          seq_d = CTC_SEQ_SETTLE;
      CTC_SEQ_SETTLE:
        if (settle_due)
          seq_d = CTC_SEQ_READY;
      CTC_SEQ_READY:
        seq_d = CTC_SEQ_READY;
    endcase
    // dropping the enable restarts the whole start-up
    if (!xtal_en)
      seq_d = CTC_SEQ_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_q <= CTC_SEQ_IDLE;
      tick_cnt_q <= '0;
      period_cnt_q <= 4'h0;
    end
    else
    begin
      seq_q <= seq_d;
      if (!timing || seq_d != seq_q)
      begin
        tick_cnt_q <= '0;
        period_cnt_q <= 4'h0;
      end
      else if (tick)
      begin
        tick_cnt_q <= '0;
        period_cnt_q <= period_cnt_q + 4'd1;
      end
      else
        tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  // trim takes effect at the apply point; later writes follow directly
  wire logic trim_live = (seq_q == CTC_SEQ_SETTLE) || (seq_q == CTC_SEQ_READY) || applying;
  wire logic [`CTC_TRIM_W-1:0] applied_d = trim_live ? trim_code_q : applied_q;
  wire logic [2:0] coarse_in = applied_d[`CTC_TRIM_W-1:`CTC_FINE_W];
  logic [`CTC_COARSE_W-1:0] coarse_dec;

  always_comb
  begin
    coarse_dec = '0;
    for (int i = 0; i < `CTC_COARSE_W; i++)
      coarse_dec[i] = (coarse_in > 3'(i)) || (i == 0);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      applied_q <= `CTC_TRIM_RST;
      fine_q <= '0;
      coarse_q <= 7'h01;
    end
    else
    begin
      applied_q <= applied_d;
      fine_q <= applied_d[`CTC_FINE_W-1:0];
      coarse_q <= coarse_dec;
    end
  end

  // coarse steps change the capacitance abruptly; pacing them is left to software
  assign trim_fine = fine_q;
  assign trim_coarse = coarse_q;
  assign fast_rc_trim = fast_trim_q;
  assign fast_crystal_osc_en = xtal_en;
  assign trim_applied_flag = (seq_q == CTC_SEQ_SETTLE) || (seq_q == CTC_SEQ_READY);
  assign crystal_settled_flag = (seq_q == CTC_SEQ_READY);
  assign sys_clk_from_crystal = crystal_settled_flag;
  // slow crystal has no trim path; it only feeds the sleep clock and calibration
  assign sleep_clk_from_crystal = ctrl_q[`CTC_CTRL_SLEEP_SEL_BIT];

  // reference counter; counting opens at the first source edge after start so that
  // the result spans N whole source periods rather than a partial first one
  wire logic cal_start = wr_sel & pwdata[`CTC_SEL_START_BIT];
  wire logic cal_count = cal_run_q & cal_armed_q;
  wire logic cal_done = cal_run_q && ((cal_target_q == '0) ||
                        (cal_count && src_rise && cal_seen_q == cal_target_q - CAL_W'(1)));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_src_q <= 2'h0;
    else if (cal_start || (wr_sel && !cal_run_q))
      cal_src_q <= pwdata[1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_run_q <= 1'b0;
    else if (cal_start)
      cal_run_q <= 1'b1;
    else if (cal_done)
      cal_run_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_armed_q <= 1'b0;
    else if (cal_start)
      cal_armed_q <= 1'b0;
    else if (cal_run_q && src_rise)
      cal_armed_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_seen_q <= '0;
    else if (cal_start)
      cal_seen_q <= '0;
    else if (cal_count && src_rise)
      cal_seen_q <= cal_seen_q + CAL_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_result_q <= '0;
    else if (cal_start)
      cal_result_q <= '0;
    else if (cal_count && xtal_rise)
      cal_result_q <= cal_result_q + CAL_W'(1);
  end

  // read mux, registered into prdata at the setup cycle
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_trim)
      rd_mux[`CTC_TRIM_W-1:0] = trim_code_q;
    if (hit_ctrl)
      rd_mux[9:0] = ctrl_q;
    if (hit_stat)
      rd_mux[1:0] = {crystal_settled_flag, trim_applied_flag};
    if (hit_fast)
      rd_mux[`CTC_FAST_TRIM_W-1:0] = fast_trim_q;
    if (hit_tgt)
      rd_mux[CAL_W-1:0] = cal_target_q;
    if (hit_sel)
      rd_mux[2:0] = {cal_run_q, cal_src_q};
    if (hit_res)
      rd_mux[CAL_W-1:0] = cal_result_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

endmodule // ctc_clock_ctrl

module ctc_edge_sync
  import ctc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic rise
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // the second and third flops feed the edge compare; the first may be metastable
  assign rise = s2_q & ~s3_q;

endmodule // ctc_edge_sync
`default_nettype wire

/* File: tb/ctc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ctc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic fast_crystal_osc_en,
  input wire logic [7:0] trim_fine,
  input wire logic [6:0] trim_coarse,
  input wire logic [3:0] fast_rc_trim,
  input wire logic sys_clk_from_crystal,
  input wire logic trim_applied_flag,
  input wire logic crystal_settled_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // only an enable from idle counts, a rewrite mid-sequence does not restart
  wire go_now = psel && penable && pwrite && paddr == 12'h004 && pwdata[8] && pwdata[3:0] == 4'h0;
  AST_COARSE_SHAPE: assert property (trim_coarse[0] && (trim_coarse & (trim_coarse + 7'h01)) == 7'h00)
    else $error("coarse trim is not a thermometer code");
  AST_APPLY_NEEDS_EN: assert property ($rose(trim_applied_flag) |-> fast_crystal_osc_en)
    else $error("trim applied without crystal enable");
  AST_FLAGS_DROP: assert property ($fell(fast_crystal_osc_en) |->
    ##[0:2] !trim_applied_flag && !crystal_settled_flag)
    else $error("flags stay up after crystal disable");
  AST_ZERO_DELAY: assert property (go_now && !fast_crystal_osc_en |-> ##[1:2] trim_applied_flag)
    else $error("zero trim delay did not apply at once");
  AST_SETTLE_ORDER: assert property (crystal_settled_flag |-> trim_applied_flag)
    else $error("settled before trim applied");
  AST_SYS_CLK: assert property (sys_clk_from_crystal == crystal_settled_flag)
    else $error("system clock source disagrees with settled flag");
  AST_TRIM_FROZEN: assert property ($changed(trim_fine) || $changed(trim_coarse) |-> trim_applied_flag)
    else $error("trim outputs moved before apply point");
  AST_RC_TRIM_RST: assert property ($rose(presetn) |-> fast_rc_trim == 4'h0)
    else $error("fast rc trim not at minimum after reset");
  cover property ($rose(crystal_settled_flag));
  cover property (go_now && !fast_crystal_osc_en);
  cover property ($rose(trim_coarse[6]));
endmodule // ctc_chk
`default_nettype wire

/* File: tb/ctc_osc.sv */
`timescale 1ns/1ps
`default_nettype none
module ctc_osc #(
  parameter int PXF = 20,
  parameter int PSR = 200,
  parameter int PFR = 24,
  parameter int PSX = 160,
  parameter int PER = 320
)
(
  input wire logic fast_crystal_osc_en,
  output var logic fast_crystal_osc_clk,
  output var logic slow_crystal_osc_clk,
  output var logic fast_rc_osc_clk,
  output var logic slow_rc_osc_clk,
  output var logic enhanced_rc_osc_clk
);
  // periods scaled down so every source stays below half of pclk
  initial
  begin
    fast_crystal_osc_clk = 1'b0;
    slow_crystal_osc_clk = 1'b0;
    fast_rc_osc_clk = 1'b0;
    slow_rc_osc_clk = 1'b0;
    enhanced_rc_osc_clk = 1'b0;
  end
  // a disabled crystal stands still, so a count without enable stays empty
  always #(PXF / 2) fast_crystal_osc_clk = fast_crystal_osc_en & ~fast_crystal_osc_clk;
  always #(PSX / 2) slow_crystal_osc_clk = ~slow_crystal_osc_clk;
  always #(PFR / 2) fast_rc_osc_clk = ~fast_rc_osc_clk;
  always #(PSR / 2) slow_rc_osc_clk = ~slow_rc_osc_clk;
  always #(PER / 2) enhanced_rc_osc_clk = ~enhanced_rc_osc_clk;
endmodule // ctc_osc
`default_nettype wire

/* File: tb/crystal_trim_clock_calibration_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module crystal_trim_clock_calibration_tb;
  localparam int T = 8;
  localparam int PER [4] = '{200, 24, 160, 320};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic fast_crystal_osc_clk, slow_crystal_osc_clk, fast_rc_osc_clk, slow_rc_osc_clk, enhanced_rc_osc_clk;
  logic fast_crystal_osc_en, sys_clk_from_crystal, sleep_clk_from_crystal, trim_applied_flag, crystal_settled_flag;
  logic [7:0] trim_fine;
  logic [6:0] trim_coarse;
  logic [3:0] fast_rc_trim;
  int bad_count = 0, checks_done = 0, cyc = 0, n, c;
  ctc_clock_ctrl #(.TICK_CYCLES(T)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fast_crystal_osc_clk, .slow_crystal_osc_clk, .fast_rc_osc_clk, .slow_rc_osc_clk,
    .enhanced_rc_osc_clk, .fast_crystal_osc_en, .trim_fine, .trim_coarse, .fast_rc_trim, .sys_clk_from_crystal,
    .sleep_clk_from_crystal, .trim_applied_flag, .crystal_settled_flag);
  ctc_osc osc_u (.fast_crystal_osc_en, .fast_crystal_osc_clk, .slow_crystal_osc_clk, .fast_rc_osc_clk,
    .slow_rc_osc_clk, .enhanced_rc_osc_clk);
  task automatic chk(input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // flags are looked at on the falling edge, clear of the update edge
  task automatic wait_flag(input bit s);
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while ((s ? crystal_settled_flag : trim_applied_flag) !== 1'b1);
  endtask
  function automatic logic [6:0] therm(input int k);
    return (k == 0) ? 7'h01 : 7'((1 << k) - 1);
  endfunction
  task automatic t_reset;
    chk(32'h1, {25'h0, trim_coarse});
    chk(32'h0, {28'h0, fast_rc_trim});
    apb(1'b0, 12'h00C, 32'h0);
    chk(32'h0, q);
    apb(1'b1, 12'h00C, 32'hF);
    apb(1'b0, 12'h00C, 32'h0);
    chk(32'hF, q);
    apb(1'b0, 12'h01C, 32'h0);
    chk(32'h1, {31'h0, e});
    $display("reset test done");
  endtask
  task automatic t_zero;
    apb(1'b1, 12'h000, 32'h3A5);
    apb(1'b1, 12'h004, 32'h110);
    wait_flag(1'b0);
    chk(32'h1, 32'(n <= 2));
    chk(32'hA5, {24'h0, trim_fine});
    chk(32'h07, {25'h0, trim_coarse});
    wait_flag(1'b1);
    chk(32'h1, {31'h0, sys_clk_from_crystal});
    apb(1'b0, 12'h008, 32'h0);
    chk(32'h3, q);
    $display("zero delay test done");
  endtask
  task automatic t_delay;
    apb(1'b1, 12'h004, 32'h0);
    repeat (3) @(negedge pclk);
    chk(32'h0, {29'h0, fast_crystal_osc_en, trim_applied_flag, crystal_settled_flag});
    apb(1'b1, 12'h004, 32'h323);
    wait_flag(1'b0);
    chk(32'h1, 32'(n >= 3 * T - 1 && n <= 3 * T + 3));
    chk(32'h1, {31'h0, sleep_clk_from_crystal});
    chk(32'h3, {29'h0, sys_clk_from_crystal, sleep_clk_from_crystal, fast_crystal_osc_en});
    wait_flag(1'b1);
    chk(32'h1, 32'(n >= 2 * T - 1 && n <= 2 * T + 3));
    $display("delay test done");
  endtask
  task automatic t_steps;
    for (int k = 2; k > 0; k--)
    begin
      apb(1'b1, 12'h000, 32'(k * 256 + 8'hA5));
      repeat (T) @(negedge pclk);
    end
    for (int k = 0; k < 15; k++)
    begin
      c = (k < 8) ? k : 14 - k;
      apb(1'b1, 12'h000, {21'h0, 3'(c), (k < 8) ? {3'(c), 5'h1F} : {3'(c), 5'h00}});
      repeat (2) @(negedge pclk);
      chk({25'h0, therm(c)}, {25'h0, trim_coarse});
      chk((k < 8) ? {24'h0, 3'(c), 5'h1F} : {24'h0, 3'(c), 5'h00}, {24'h0, trim_fine});
      repeat (T) @(negedge pclk);
    end
    $display("trim step test done");
  endtask
  task automatic t_cal;
    for (int s = 0; s < 5; s++)
    begin
      c = s % 4; // slow RC measured again in a later active period
      apb(1'b1, 12'h010, 32'h5);
      apb(1'b1, 12'h014, 32'(4 + c));
      apb(1'b0, 12'h014, 32'h0);
      chk(32'h1, {31'h0, q[2]});
      while (q[2] !== 1'b0) apb(1'b0, 12'h014, 32'h0);
      chk(32'(c), {30'h0, q[1:0]});
      apb(1'b0, 12'h018, 32'h0);
      chk(32'h1, 32'(q >= 5 * PER[c] / 20 - 2 && q <= 5 * PER[c] / 20 + 2));
    end
    $display("calibration test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      stop_test;
    end
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset;
    t_zero;
    t_delay;
    t_steps;
    t_cal;
    stop_test;
  end
endmodule // crystal_trim_clock_calibration_tb
bind ctc_clock_ctrl ctc_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .fast_crystal_osc_en(fast_crystal_osc_en), .trim_fine(trim_fine),
  .trim_coarse(trim_coarse), .fast_rc_trim(fast_rc_trim), .sys_clk_from_crystal(sys_clk_from_crystal),
  .trim_applied_flag(trim_applied_flag), .crystal_settled_flag(crystal_settled_flag));
`default_nettype wire
